/* File: verilog/lwdt_top.sv */
// Summary of operation
// - the supervision timer counter advances on slow oscillator ticks of 80 kHz.
// - an overflow of the counter asserts the chip-wide reset request.
// - after reset the timer is enabled, counting, at the longest interval.
// - while unlocked, software may clear the enable to stop timeouts.
// - once locked, writes that disable or reconfigure are ignored until reset.
// - the watchdog reset drives only internal reset, never the external pin.
module lwdt_top
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_int_rst_req,
   output logic o_wdt_caused
);
   import lwdt_pkg::*;

   localparam logic [LWDT_PRE_W-1:0] PRE_LAST = LWDT_PRE_W'(LWDT_TICK_CYC - 1);
   localparam logic [LWDT_RPULSE_W-1:0] RP_LEN = LWDT_RPULSE_W'(LWDT_RST_CYC);

   typedef struct packed
   {
      logic en;
      logic lock;
      logic [LWDT_SEL_W-1:0] sel;
      logic [LWDT_PRE_W-1:0] pre;
      logic [LWDT_CNT_W-1:0] cnt;
      logic [LWDT_RPULSE_W-1:0] rp;
      logic caused;
      logic req;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lwdt_state_s;

   lwdt_state_s s_reg;
   lwdt_state_s s_next;

   // interval length in slow ticks for a select code
   function automatic logic [LWDT_CNT_W-1:0] limit_of
   (
      input logic [LWDT_SEL_W-1:0] sel
   );
      limit_of = LWDT_CNT_W'(1) << (LWDT_BASE_EXP + 32'(sel));
   endfunction : limit_of

   function automatic logic addr_ok
   (
      input logic [11:0] a
   );
      case (a)
         LWDT_CTRL_OFS,
         LWDT_RESTART_OFS,
         LWDT_STAT_OFS:
         begin
            addr_ok = 1'b1;
         end
         default:
         begin
            addr_ok = 1'b0;
         end
      endcase
   endfunction : addr_ok

   // write that lands in the access phase of a transfer to one offset
   function automatic logic wr_hit
   (
      input logic acc_ph,
      input logic wr,
      input logic [3:0] strb,
      input logic [11:0] a,
      input logic [11:0] ofs
   );
      wr_hit = acc_ph && wr && strb[0] && (a == ofs);
   endfunction : wr_hit

   // read data is taken from the state in the setup cycle
   function automatic logic [31:0] read_word
   (
      input logic [11:0] a,
      input lwdt_state_s st
   );
      logic [31:0] w;
      w = '0;
      case (a)
         LWDT_CTRL_OFS:
         begin
            w[LWDT_CTRL_EN_BIT] = st.en;
            w[LWDT_CTRL_LOCK_BIT] = st.lock;
            w[LWDT_CTRL_SEL_LSB +: LWDT_SEL_W] = st.sel;
         end
         LWDT_STAT_OFS:
         begin
            w[LWDT_CNT_W-1:0] = st.cnt;
            w[LWDT_STAT_CAUSED_BIT] = st.caused;
         end
         default:
         begin
            w = '0;
         end
      endcase
      read_word = w;
   endfunction : read_word

   logic setup;
   logic acc;
   logic tick;
   logic wr_ctrl;
   logic wr_restart;
   logic ctrl_ok;

   always_comb
   begin
      setup = i_psel && !i_penable;
      acc = i_psel && i_penable && s_reg.pready;
      tick = (s_reg.pre == PRE_LAST);
      wr_ctrl = wr_hit(acc, i_pwrite, i_pstrb, i_paddr, LWDT_CTRL_OFS);
      wr_restart = wr_hit(acc, i_pwrite, i_pstrb, i_paddr, LWDT_RESTART_OFS)
         && (i_pwdata[$bits(LWDT_RESTART_KEY)-1:0] == LWDT_RESTART_KEY);
      ctrl_ok = wr_ctrl && !s_reg.lock;

      s_next = s_reg;
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      // free-running prescaler stands in for the slow oscillator
      s_next.pre = tick ? '0 : s_reg.pre + 1'b1;
      if (s_reg.rp != '0)
      begin
         s_next.rp = s_reg.rp - 1'b1;
      end

      // a set lock also forces the enable, so a locked timer is never off
      if (ctrl_ok)
      begin
         s_next.en = i_pwdata[LWDT_CTRL_EN_BIT];
         s_next.lock = i_pwdata[LWDT_CTRL_LOCK_BIT];
         if (i_pwdata[LWDT_CTRL_LOCK_BIT])
         begin
            s_next.en = 1'b1;
         end
         s_next.sel = i_pwdata[LWDT_CTRL_SEL_LSB +: LWDT_SEL_W];
         s_next.cnt = '0;
      end

      // a restart or accepted control write wins over a tick in the same cycle
      if (wr_restart || ctrl_ok)
      begin
         s_next.cnt = '0;
      end
      // counting pauses while the reset request stands
      else if (s_reg.en && tick && s_reg.rp == '0)
      begin
         if (s_reg.cnt + 1'b1 >= limit_of(s_reg.sel))
         begin
            s_next.cnt = '0;
            s_next.rp = RP_LEN;
            s_next.caused = 1'b1;
         end
         else
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
         end
      end
      if (s_reg.rp == LWDT_RPULSE_W'(1))
      begin
         // internal reset restores defaults, apart from the cause flag
         s_next.en = LWDT_EN_RST;
         s_next.lock = LWDT_LOCK_RST;
         s_next.sel = LWDT_SEL_MAX;
         s_next.cnt = '0;
      end

      // the answer comes in the next cycle: the access phase never waits
      if (setup)
      begin
         s_next.pready = 1'b1;
         s_next.pslverr = !addr_ok(i_paddr);
         s_next.prdata = read_word(i_paddr, s_reg);
      end

      // a new overflow wins over a status read in the same cycle
      if (acc && !i_pwrite && i_paddr == LWDT_STAT_OFS)
      begin
         s_next.caused = 1'b0;
      end
      if (s_reg.rp == '0 && s_next.rp != '0)
      begin
         s_next.caused = 1'b1;
      end
      s_next.req = (s_next.rp != '0);
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         s_reg <= '0;
         s_reg.en <= LWDT_EN_RST;
         s_reg.lock <= LWDT_LOCK_RST;
         s_reg.sel <= LWDT_SEL_MAX;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign o_prdata = s_reg.prdata;
   assign o_pready = s_reg.pready;
   assign o_pslverr = s_reg.pslverr;
   assign o_int_rst_req = s_reg.req;
   assign o_wdt_caused = s_reg.caused;
endmodule : lwdt_top

/* File: verilog/lwdt_pkg.sv */
package lwdt_pkg;
   // register map, byte addresses
   localparam logic [11:0] LWDT_CTRL_OFS = 12'h000;
   localparam logic [11:0] LWDT_RESTART_OFS = 12'h004;
   localparam logic [11:0] LWDT_STAT_OFS = 12'h008;
   // control and status field positions
   localparam int LWDT_CTRL_EN_BIT = 0;
   localparam int LWDT_CTRL_LOCK_BIT = 1;
   localparam int LWDT_CTRL_SEL_LSB = 4;
   localparam int LWDT_SEL_W = 3;
   localparam int LWDT_STAT_CAUSED_BIT = 31;
   // restart key in the low byte of a restart write
   localparam logic [7:0] LWDT_RESTART_KEY = 8'hA5;
   localparam logic [LWDT_SEL_W-1:0] LWDT_SEL_MAX = 3'h7;
   localparam logic LWDT_EN_RST = 1'b1;
   localparam logic LWDT_LOCK_RST = 1'b0;
   // slow oscillator: 80 kHz tick from 100 MHz core clock
   localparam int LWDT_CORE_HZ = 100_000_000;
   localparam int LWDT_SLOW_HZ = 80_000;
   localparam int LWDT_TICK_CYC = LWDT_CORE_HZ / LWDT_SLOW_HZ;
   localparam int LWDT_PRE_W = 11;
   // interval = 2^(LWDT_BASE_EXP + sel) slow-oscillator ticks
   localparam int LWDT_BASE_EXP = 6;
   localparam int LWDT_CNT_W = 14;
   localparam int LWDT_RST_CYC = 16;
   localparam int LWDT_RPULSE_W = 5;
endpackage : lwdt_pkg

/* File: test/lwdt_chk_sva.sv */
module lwdt_chk
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_int_rst_req,
   input wire logic o_wdt_caused
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_hold;
      o_int_rst_req[*8] ##1 o_int_rst_req[*8] ##1 !o_int_rst_req;
   endsequence
   property p_ans;
      i_psel && !i_penable |=> o_pready;
   endproperty
   property p_pulse;
      o_pready |=> !o_pready;
   endproperty
   property p_err;
      o_pslverr |-> o_pready;
   endproperty
   property p_req;
      $rose(o_int_rst_req) |-> s_hold;
   endproperty
   property p_cause;
      $rose(o_int_rst_req) |-> ##[0:1] o_wdt_caused;
   endproperty
   property p_quiet;
      $fell(o_int_rst_req) |-> !o_int_rst_req[*8];
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   a_pulse: assert property (p_pulse) else $error("ready too long");
   a_err: assert property (p_err) else $error("stray error");
   a_req: assert property (p_req) else $error("reset pulse length");
   a_cause: assert property (p_cause) else $error("cause flag missing");
   a_quiet: assert property (p_quiet) else $error("reset repeats");
endmodule : lwdt_chk

bind lwdt_top lwdt_chk chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
   .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_int_rst_req(o_int_rst_req), .o_wdt_caused(o_wdt_caused));

/* File: test/lowfreq_watchdog_timer_tb_top.sv */
module lowfreq_watchdog_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import lwdt_pkg::*;
   logic clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, rdy, er, req, cz, e;
   logic [11:0] addr = '0;
   logic [31:0] wd = '0, rd, q, p;
   // the restart lands four edges before the overflow wait starts; tick phase is unknown
   localparam int OVF_LO = ((1 << LWDT_BASE_EXP) - 1) * LWDT_TICK_CYC - 2;
   localparam int OVF_HI = (1 << LWDT_BASE_EXP) * LWDT_TICK_CYC - 3;
   int err_count = 0, comparisons = 0, n;
   always #5 clk = ~clk;
   lwdt_top dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(sel), .i_penable(en),
      .i_pwrite(wr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(rd),
      .o_pready(rdy), .o_pslverr(er), .o_int_rst_req(req), .o_wdt_caused(cz));
   function automatic logic [31:0] ctrl(logic v, logic l, logic [2:0] s);
      return (32'(v) << LWDT_CTRL_EN_BIT) | (32'(l) << LWDT_CTRL_LOCK_BIT)
         | (32'(s) << LWDT_CTRL_SEL_LSB);
   endfunction : ctrl
   task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
      comparisons++;
      if (s !== x)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, x, s);
      end
   endtask : chk
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      sel <= 1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      en <= 1;
      do @(posedge clk); while (rdy !== 1'b1);
      q = rd;
      e = er;
      sel <= 0;
      en <= 0;
      @(posedge clk);
   endtask : bus
   task automatic final_report;
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (95000) @(posedge clk);
      err_count++;
      final_report;
   end
   initial
   begin
      void'($urandom(32'h7886));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      bus(0, LWDT_CTRL_OFS, 0);
      chk("ctrl_rst", ctrl(LWDT_EN_RST, LWDT_LOCK_RST, LWDT_SEL_MAX), q);
      bus(0, 12'({10'($urandom_range(3, 1023)), 2'b00}), 0);
      chk("slverr", 1, 32'(e));
      chk("bad_rd", 0, q);
      bus(1, LWDT_CTRL_OFS, ctrl(1, 0, 0));
      bus(1, LWDT_CTRL_OFS, ctrl(1, 1, 0));
      bus(1, LWDT_CTRL_OFS, ctrl(0, 0, 3'($urandom)));
      bus(1, LWDT_RESTART_OFS, {24'($urandom), LWDT_RESTART_KEY});
      bus(0, LWDT_CTRL_OFS, 0);
      chk("ctrl_lock", ctrl(1, 1, 0), q);
      n = 0;
      while (req !== 1'b1 && n++ < 85000) @(posedge clk);
      chk("int_rst", 1, 32'(req));
      chk("ovf_cycles", n < OVF_LO ? OVF_LO : (n > OVF_HI ? OVF_HI : n), n);
      n = 0;
      while (req === 1'b1)
      begin
         n++;
         @(posedge clk);
      end
      chk("pulse_len", LWDT_RST_CYC, n);
      chk("caused_pin", 1, 32'(cz));
      bus(0, LWDT_STAT_OFS, 0);
      chk("caused", 1, 32'(q[LWDT_STAT_CAUSED_BIT]));
      bus(0, LWDT_STAT_OFS, 0);
      chk("caused_clr", 0, 32'(q[LWDT_STAT_CAUSED_BIT]));
      chk("caused_pin_clr", 0, 32'(cz));
      bus(0, LWDT_CTRL_OFS, 0);
      chk("ctrl_reload", ctrl(1, 0, 7), q);
      bus(1, LWDT_CTRL_OFS, 0);
      bus(0, LWDT_CTRL_OFS, 0);
      chk("ctrl_off", 0, q);
      bus(0, LWDT_STAT_OFS, 0);
      p = q;
      repeat (2 * LWDT_TICK_CYC) @(posedge clk);
      bus(0, LWDT_STAT_OFS, 0);
      chk("cnt_held", p, q);
      final_report;
   end
endmodule : lowfreq_watchdog_timer_tb_top
